// File: hdl/comm_dip_switch_config.sv
// Power-up decoder for the switch bank: serial, fieldbus and network settings
`timescale 1ns/1ps
`include "dip_cfg.svh"

module comm_dip_switch_config
  import dip_cfg_pkg::*;
(
  // Clock and reset
  input wire logic CLK,
  input wire logic NRST,
  // Switch bank and option card pins
  input wire logic [9:0] DIP_SW,
  input wire logic FIELDBUS_CARD,
  input wire logic ETHERNET_CARD,
  input wire logic SERIAL_FITTED,
  // Register port
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  // Serial port settings
  output logic SER_EN,
  output logic [7:0] SER_NODE,
  output logic [1:0] SER_BAUD,
  output logic SER_STOP2,
  output logic SER_ODD,
  output logic SER_ASCII,
  // Fieldbus card settings
  output logic FB_EN,
  output logic [7:0] FB_NODE,
  // Network card settings
  output logic NET_EN,
  output logic [31:0] NET_IP,
  output logic [31:0] NET_MASK,
  output logic [31:0] NET_GW,
  // Settings valid
  output logic CFG_DONE
);

  // ****************************************
  // Timing
  // ****************************************
  // Wait for the pin synchronisers to fill before sampling
  localparam int SETTLE_CYC_I = (`SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam logic [3:0] SETTLE_CYC = 4'(SETTLE_CYC_I);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [12:0] pins_s;
  logic [9:0] dip_s;
  logic fb_card_s;
  logic eth_card_s;
  logic ser_fit_s;

  sync_bits #(.WIDTH(13)) u_sync (
    .clk(CLK),
    .nrst(NRST),
    .d({SERIAL_FITTED, ETHERNET_CARD, FIELDBUS_CARD, DIP_SW}),
    .q(pins_s)
  );

  assign dip_s = pins_s[9:0];
  assign fb_card_s = pins_s[10];
  assign eth_card_s = pins_s[11];
  assign ser_fit_s = pins_s[12];

  // ****************************************
  // Software registers
  // ****************************************
  logic [7:0] sw_addr_r;
  logic [7:0] sw_addr_nxt;
  baud_t sw_baud_r;
  baud_t sw_baud_nxt;
  logic [2:0] framing_r;
  logic [2:0] framing_nxt;
  logic [31:0] nv_ip_r;
  logic [31:0] nv_ip_nxt;
  logic [31:0] nv_mask_r;
  logic [31:0] nv_mask_nxt;
  logic [31:0] nv_gw_r;
  logic [31:0] nv_gw_nxt;
  logic soft_req_r;
  logic soft_req_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;

  // Captured state, declared early for readback
  state_t state_r;
  card_t mode_r;
  logic [9:0] dip_cap_r;

  always_comb begin
    sw_addr_nxt = sw_addr_r;
    sw_baud_nxt = sw_baud_r;
    framing_nxt = framing_r;
    nv_ip_nxt = nv_ip_r;
    nv_mask_nxt = nv_mask_r;
    nv_gw_nxt = nv_gw_r;
    soft_req_nxt = 1'b0;
    if (WR) begin
      case (ADDR)
        `OFF_SW_ADDR: begin
          // Out-of-range addresses are dropped, old value kept
          if (WDATA[7:0] >= `SER_ADDR_MIN && WDATA[7:0] <= `SER_ADDR_MAX
              && WDATA[31:8] == 24'h000000) begin
            sw_addr_nxt = WDATA[7:0];
          end
        end
        `OFF_SW_BAUD: begin
          // Code 00 names no rate, so it is refused
          if (WDATA[1:0] != BAUD_SOFT && WDATA[31:2] == 30'h00000000) begin
            sw_baud_nxt = baud_t'(WDATA[1:0]);
          end
        end
        `OFF_FRAMING: begin
          framing_nxt = WDATA[2:0];
        end
        `OFF_NV_IP: begin
          nv_ip_nxt = WDATA;
        end
        `OFF_NV_MASK: begin
          nv_mask_nxt = WDATA;
        end
        `OFF_NV_GW: begin
          nv_gw_nxt = WDATA;
        end
        `OFF_COMMAND: begin
          soft_req_nxt = (WDATA == `CMD_SOFT_RESET);
        end
        default: begin
          sw_addr_nxt = sw_addr_r;
        end
      endcase
    end
  end

  always_comb begin
    rdata_nxt = 32'h00000000;
    if (RD) begin
      case (ADDR)
        `OFF_SW_ADDR: rdata_nxt = {24'h000000, sw_addr_r};
        `OFF_SW_BAUD: rdata_nxt = {30'h00000000, sw_baud_r};
        `OFF_FRAMING: rdata_nxt = {29'h00000000, framing_r};
        `OFF_NV_IP: rdata_nxt = nv_ip_r;
        `OFF_NV_MASK: rdata_nxt = nv_mask_r;
        `OFF_NV_GW: rdata_nxt = nv_gw_r;
        `OFF_STATUS: rdata_nxt = {16'h0000, state_r, mode_r, 2'b00, dip_cap_r};
        `OFF_ACT_SER: rdata_nxt = {SER_EN, 18'h00000, SER_ASCII, SER_ODD, SER_STOP2,
                                   SER_BAUD, SER_NODE};
        `OFF_ACT_IP: rdata_nxt = NET_IP;
        default: rdata_nxt = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      sw_addr_r <= `RST_SW_ADDR;
      sw_baud_r <= baud_t'(`RST_SW_BAUD);
      framing_r <= `RST_FRAMING;
      nv_ip_r <= `RST_NV_IP;
      nv_mask_r <= `RST_NV_MASK;
      nv_gw_r <= `RST_NV_GW;
      soft_req_r <= 1'b0;
      rdata_r <= 32'h00000000;
    end else begin
      sw_addr_r <= sw_addr_nxt;
      sw_baud_r <= sw_baud_nxt;
      framing_r <= framing_nxt;
      nv_ip_r <= nv_ip_nxt;
      nv_mask_r <= nv_mask_nxt;
      nv_gw_r <= nv_gw_nxt;
      soft_req_r <= soft_req_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // ****************************************
  // Sampling sequence
  // ****************************************
  state_t state_nxt;
  logic [3:0] settle_r;
  logic [3:0] settle_nxt;

  always_comb begin
    state_nxt = state_r;
    settle_nxt = settle_r;
    case (state_r)
      ST_SETTLE: begin
        if (settle_r >= SETTLE_CYC) begin
          state_nxt = ST_CAPTURE;
        end else begin
          settle_nxt = settle_r + 4'h1;
        end
      end
      ST_CAPTURE: begin
        state_nxt = ST_RUN;
      end
      ST_RUN: begin
        // Switches are not looked at again until a soft reset
        if (soft_req_r) begin
          state_nxt = ST_SETTLE;
          settle_nxt = 4'h0;
        end
      end
      default: begin
        state_nxt = ST_SETTLE;
        settle_nxt = 4'h0;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      state_r <= ST_SETTLE;
      settle_r <= 4'h0;
    end else begin
      state_r <= state_nxt;
      settle_r <= settle_nxt;
    end
  end

  // ****************************************
  // Switch decode
  // ****************************************
  card_t mode;
  logic [7:0] dip_addr;
  baud_t dip_rate;
  logic [7:0] octet;
  logic [7:0] ser_node;
  baud_t ser_baud;
  logic [7:0] fb_node;
  logic [31:0] net_ip;
  logic [31:0] net_mask;
  logic [31:0] net_gw;

  always_comb begin
    // Ethernet wins if both cards report present
    mode = MODE_PLAIN;
    if (eth_card_s) begin
      mode = MODE_ETHERNET;
    end else if (fb_card_s) begin
      mode = MODE_FIELDBUS;
    end
    // Switch ten never reaches any decode below
    dip_addr = {1'b0, dip_s[6:0]};
    dip_rate = baud_t'({dip_s[`DIP_RATE_HI_BIT], dip_s[`DIP_RATE_LO_BIT]});
    octet = dip_s[7:0];
    ser_node = sw_addr_r;
    ser_baud = sw_baud_r;
    fb_node = 8'h00;
    net_ip = {`NET_PREFIX, `NET_DEFAULT_OCTET};
    net_mask = `NET_FIXED_MASK;
    net_gw = `NET_FIXED_GW;
    case (mode)
      MODE_PLAIN, MODE_FIELDBUS: begin
        if (dip_addr != 8'h00) begin
          ser_node = dip_addr;
        end
        // All-zero address switches hand the address to software
        if (dip_addr == 8'h00) begin
          ser_node = sw_addr_r;
        end
        if (dip_rate != BAUD_SOFT) begin
          ser_baud = dip_rate;
        end
        fb_node = ser_node;
      end
      MODE_ETHERNET: begin
        ser_node = sw_addr_r;
        ser_baud = sw_baud_r;
        if (!dip_s[`DIP_NET_SEL_BIT]) begin
          // Octets 254 and 255 are outside the fixed range
          if (octet <= `NET_OCTET_MAX) begin
            net_ip = {`NET_PREFIX, octet};
          end
        end else if (dip_s[8:0] == `DIP_NV_PATTERN) begin
          net_ip = nv_ip_r;
          net_mask = nv_mask_r;
          net_gw = nv_gw_r;
        end else begin
          net_ip = nv_ip_r;
          net_mask = nv_mask_r;
          net_gw = nv_gw_r;
        end
      end
      default: begin
        ser_node = sw_addr_r;
      end
    endcase
  end

  // ****************************************
  // Captured outputs
  // ****************************************
  card_t mode_nxt;
  logic [9:0] dip_cap_nxt;
  logic ser_en_r;
  logic ser_en_nxt;
  logic [7:0] ser_node_r;
  logic [7:0] ser_node_nxt;
  baud_t ser_baud_r;
  baud_t ser_baud_nxt;
  logic [2:0] ser_frm_r;
  logic [2:0] ser_frm_nxt;
  logic fb_en_r;
  logic fb_en_nxt;
  logic [7:0] fb_node_r;
  logic [7:0] fb_node_nxt;
  logic net_en_r;
  logic net_en_nxt;
  logic [31:0] net_ip_r;
  logic [31:0] net_ip_nxt;
  logic [31:0] net_mask_r;
  logic [31:0] net_mask_nxt;
  logic [31:0] net_gw_r;
  logic [31:0] net_gw_nxt;
  logic done_r;
  logic done_nxt;

  always_comb begin
    mode_nxt = mode_r;
    dip_cap_nxt = dip_cap_r;
    ser_en_nxt = ser_en_r;
    ser_node_nxt = ser_node_r;
    ser_baud_nxt = ser_baud_r;
    ser_frm_nxt = ser_frm_r;
    fb_en_nxt = fb_en_r;
    fb_node_nxt = fb_node_r;
    net_en_nxt = net_en_r;
    net_ip_nxt = net_ip_r;
    net_mask_nxt = net_mask_r;
    net_gw_nxt = net_gw_r;
    done_nxt = (state_r == ST_RUN) && !soft_req_r;
    // Only the capture state loads; running values stay frozen
    if (state_r == ST_CAPTURE) begin
      mode_nxt = mode;
      dip_cap_nxt = dip_s;
      ser_en_nxt = ser_fit_s;
      ser_node_nxt = ser_node;
      ser_baud_nxt = ser_baud;
      ser_frm_nxt = framing_r;
      fb_en_nxt = (mode == MODE_FIELDBUS);
      fb_node_nxt = fb_node;
      net_en_nxt = (mode == MODE_ETHERNET);
      net_ip_nxt = net_ip;
      net_mask_nxt = net_mask;
      net_gw_nxt = net_gw;
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      mode_r <= MODE_PLAIN;
      dip_cap_r <= 10'h000;
      ser_en_r <= 1'b0;
      ser_node_r <= `RST_SW_ADDR;
      ser_baud_r <= baud_t'(`RST_SW_BAUD);
      ser_frm_r <= `RST_FRAMING;
      fb_en_r <= 1'b0;
      fb_node_r <= 8'h00;
      net_en_r <= 1'b0;
      net_ip_r <= {`NET_PREFIX, `NET_DEFAULT_OCTET};
      net_mask_r <= `NET_FIXED_MASK;
      net_gw_r <= `NET_FIXED_GW;
      done_r <= 1'b0;
    end else begin
      mode_r <= mode_nxt;
      dip_cap_r <= dip_cap_nxt;
      ser_en_r <= ser_en_nxt;
      ser_node_r <= ser_node_nxt;
      ser_baud_r <= ser_baud_nxt;
      ser_frm_r <= ser_frm_nxt;
      fb_en_r <= fb_en_nxt;
      fb_node_r <= fb_node_nxt;
      net_en_r <= net_en_nxt;
      net_ip_r <= net_ip_nxt;
      net_mask_r <= net_mask_nxt;
      net_gw_r <= net_gw_nxt;
      done_r <= done_nxt;
    end
  end

  // ****************************************
  // Output wiring
  // ****************************************
  assign RDATA = rdata_r;
  assign SER_EN = ser_en_r;
  assign SER_NODE = ser_node_r;
  assign SER_BAUD = ser_baud_r;
  assign SER_STOP2 = ser_frm_r[`FRM_STOP2_BIT];
  assign SER_ODD = ser_frm_r[`FRM_ODD_BIT];
  assign SER_ASCII = ser_frm_r[`FRM_ASCII_BIT];
  assign FB_EN = fb_en_r;
  assign FB_NODE = fb_node_r;
  assign NET_EN = net_en_r;
  assign NET_IP = net_ip_r;
  assign NET_MASK = net_mask_r;
  assign NET_GW = net_gw_r;
  assign CFG_DONE = done_r;

endmodule

// File: hdl/dip_cfg.svh
// Constants for the switch bank decoder: offsets, fields, reset values, timing
`ifndef DIP_CFG_SVH
`define DIP_CFG_SVH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define OFF_SW_ADDR 8'h00
`define OFF_SW_BAUD 8'h04
`define OFF_FRAMING 8'h08
`define OFF_NV_IP 8'h0C
`define OFF_NV_MASK 8'h10
`define OFF_NV_GW 8'h14
`define OFF_COMMAND 8'h18
`define OFF_STATUS 8'h1C
`define OFF_ACT_SER 8'h20
`define OFF_ACT_IP 8'h24

// ****************************************
// Field positions
// ****************************************
`define FRM_STOP2_BIT 0
`define FRM_ODD_BIT 1
`define FRM_ASCII_BIT 2
`define DIP_RATE_LO_BIT 7
`define DIP_RATE_HI_BIT 8
`define DIP_NET_SEL_BIT 8
`define DIP_RESERVED_BIT 9
`define DIP_NV_PATTERN 9'h102

// ****************************************
// Reset values and limits
// ****************************************
`define RST_SW_ADDR 8'h01
`define RST_SW_BAUD 2'h3
`define RST_FRAMING 3'h0
`define RST_NV_IP 32'hC0A801FE
`define RST_NV_MASK 32'hFFFFFF00
`define RST_NV_GW 32'hC0A80101
`define NET_PREFIX 24'hC0A801
`define NET_DEFAULT_OCTET 8'hFE
`define NET_FIXED_MASK 32'hFFFFFF00
`define NET_FIXED_GW 32'hC0A80101
`define NET_OCTET_MAX 8'hFD
`define SER_ADDR_MIN 8'h01
`define SER_ADDR_MAX 8'hF7
`define CMD_SOFT_RESET 32'h00000006

// ****************************************
// Timing
// ****************************************
`define CLK_PERIOD_NS 5
`define SETTLE_NS 20

`endif

// File: hdl/dip_cfg_pkg.sv
// Types shared by the switch bank decoder
package dip_cfg_pkg;

  typedef enum logic [1:0] {
    BAUD_SOFT = 2'b00,
    BAUD_9600 = 2'b01,
    BAUD_115200 = 2'b10,
    BAUD_19200 = 2'b11
  } baud_t;

  typedef enum logic [1:0] {
    MODE_PLAIN = 2'b00,
    MODE_FIELDBUS = 2'b01,
    MODE_ETHERNET = 2'b10
  } card_t;

  typedef enum logic [1:0] {
    ST_SETTLE = 2'b00,
    ST_CAPTURE = 2'b01,
    ST_RUN = 2'b10
  } state_t;

endpackage

// File: hdl/sync_bits.sv
// Two-stage synchroniser for a group of pin inputs
`timescale 1ns/1ps
module sync_bits #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Pins in, synchronised out
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      logic meta_r;
      logic hold_r;
      // First stage feeds only the second
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          meta_r <= 1'b0;
          hold_r <= 1'b0;
        end else begin
          meta_r <= d[i];
          hold_r <= meta_r;
        end
      end
      assign q[i] = hold_r;
    end
  endgenerate

endmodule

// File: tb/comm_dip_switch_config_test.sv
// Self-checking bench for the switch bank decoder
`timescale 1ns/1ps
`include "dip_cfg.svh"
module comm_dip_switch_config_test;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [9:0] dip = 10'h000;
  logic fb = 1'b0;
  logic eth = 1'b0;
  logic ser_fit = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata, ip, mask, gw;
  logic ser_en, stop2, odd, ascii, fb_en, net_en, done, clash, same;
  logic [7:0] node, fb_node;
  logic [1:0] baud;
  logic [7:0] oct [5] = '{8'h05, 8'h00, 8'hFD, 8'hFE, 8'hFF};
  logic [7:0] exp [5] = '{8'h05, 8'h00, 8'hFD, 8'hFE, 8'hFE};
  int fail_count = 0;
  int compares = 0;
  int cyc = 0;
  always #2.5 clk = ~clk;
  comm_dip_switch_config i_comm_dip_switch_config (
    .CLK(clk), .NRST(nrst), .DIP_SW(dip), .FIELDBUS_CARD(fb), .ETHERNET_CARD(eth),
    .SERIAL_FITTED(ser_fit), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
    .SER_EN(ser_en), .SER_NODE(node), .SER_BAUD(baud), .SER_STOP2(stop2), .SER_ODD(odd),
    .SER_ASCII(ascii), .FB_EN(fb_en), .FB_NODE(fb_node), .NET_EN(net_en), .NET_IP(ip),
    .NET_MASK(mask), .NET_GW(gw), .CFG_DONE(done));
  serial_peer_model i_serial_peer_model (
    .node(node), .baud(baud), .done(done), .clash(clash), .same(same));
  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input string n, input logic [63:0] s, input logic [63:0] e);
    compares++;
    if (s !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic end_sim;
    $display("Compares %0d, mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] e, input string n);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(n, rdata, e);
  endtask
  // Bounded wait; the first edges let a soft reset pull CFG_DONE down
  task automatic wait_done;
    int n;
    n = 0;
    repeat (4) @(posedge clk);
    while (done !== 1'b1 && n < 40) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("done", done, 1'b1);
  endtask
  task automatic boot(input logic [9:0] d, input logic f, input logic e);
    @(posedge clk);
    nrst <= 1'b0;
    dip <= d;
    fb <= f;
    eth <= e;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    wait_done();
  endtask
  task automatic soft_rst;
    wr_reg(`OFF_COMMAND, `CMD_SOFT_RESET);
    wait_done();
  endtask
  task automatic ser_chk(input logic [7:0] n, input logic [1:0] b, input logic [2:0] f);
    chk("node", node, n);
    chk("baud", baud, b);
    chk("frame", {ascii, odd, stop2}, f);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      end_sim();
    end
  end
  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    boot(10'h000, 1'b0, 1'b0);
    ser_chk(8'h01, 2'h3, 3'h0);
    chk("peer", {clash, same}, 2'b01);
    chk("ser_en", ser_en, 1'b1);
    rd_reg(`OFF_SW_ADDR, 32'h1, "sw_addr");
    rd_reg(`OFF_SW_BAUD, 32'h3, "sw_baud");
    rd_reg(`OFF_FRAMING, 32'h0, "framing");
    rd_reg(`OFF_NV_IP, `RST_NV_IP, "nv_ip");
    rd_reg(8'h40, 32'h0, "unmapped");
    // Rate codes 1 to 3, switch ten set to show it is ignored
    for (int r = 1; r < 4; r++) begin
      boot({1'b1, r[1:0], 7'h25}, 1'b0, 1'b0);
      ser_chk(8'h25, r[1:0], 3'h0);
      chk("cards", {fb_en, net_en, fb_node}, 10'h025);
    end
    @(posedge clk);
    dip <= 10'h000;
    repeat (10) @(posedge clk);
    chk("hold", node, 8'h25);
    // Edge of the address range, refused values
    wr_reg(`OFF_SW_ADDR, 32'hF7);
    wr_reg(`OFF_SW_ADDR, 32'hF8);
    wr_reg(`OFF_SW_BAUD, 32'h1);
    wr_reg(`OFF_SW_BAUD, 32'h0);
    wr_reg(`OFF_FRAMING, 32'h7);
    rd_reg(`OFF_SW_ADDR, 32'hF7, "sw_addr");
    rd_reg(`OFF_SW_BAUD, 32'h1, "sw_baud");
    soft_rst();
    ser_chk(8'hF7, 2'h1, 3'h7);
    // Serial port left out once, then fitted again in run before the next boot
    @(posedge clk);
    ser_fit <= 1'b0;
    boot(10'h1E4, 1'b1, 1'b0);
    ser_chk(8'h64, 2'h3, 3'h0);
    chk("fb_node", {fb_en, fb_node}, 9'h164);
    chk("ser_en", ser_en, 1'b0);
    rd_reg(`OFF_STATUS, 32'h000091E4, "status");
    rd_reg(`OFF_ACT_SER, 32'h00000364, "act_ser");
    @(posedge clk);
    ser_fit <= 1'b1;
    // Low octet edges; 254 and 255 fall back to the default host
    foreach (oct[i]) begin
      boot({2'b10, oct[i]}, 1'b0, 1'b1);
      chk("ip", ip, {`NET_PREFIX, exp[i]});
      chk("mask_gw", {mask, gw}, {`NET_FIXED_MASK, `NET_FIXED_GW});
      ser_chk(8'h01, 2'h3, 3'h0);
      chk("en", {net_en, fb_en}, 2'b10);
    end
    wr_reg(`OFF_NV_IP, 32'h0A000002);
    wr_reg(`OFF_NV_MASK, 32'hFFFF0000);
    wr_reg(`OFF_NV_GW, 32'h0A000001);
    // Stored pattern (switch ten also on), then a reserved one
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      dip <= k ? 10'h180 : 10'h302;
      soft_rst();
      chk("nv_ip", ip, 32'h0A000002);
      chk("nv_mg", {mask, gw}, {32'hFFFF0000, 32'h0A000001});
    end
    rd_reg(`OFF_ACT_IP, 32'h0A000002, "act_ip");
    end_sim();
  end
endmodule

// File: tb/dip_cfg_asserts.sv
// Checker for the switch bank decoder, bound to its ports
`timescale 1ns/1ps
`include "dip_cfg.svh"
module dip_cfg_asserts (
  // Clock, reset, pins
  input wire logic CLK,
  input wire logic NRST,
  input wire logic [9:0] DIP_SW,
  input wire logic FIELDBUS_CARD,
  input wire logic ETHERNET_CARD,
  input wire logic SERIAL_FITTED,
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  // Outputs
  input wire logic [31:0] RDATA,
  input wire logic SER_EN,
  input wire logic [7:0] SER_NODE,
  input wire logic [1:0] SER_BAUD,
  input wire logic SER_STOP2,
  input wire logic SER_ODD,
  input wire logic SER_ASCII,
  input wire logic FB_EN,
  input wire logic [7:0] FB_NODE,
  input wire logic NET_EN,
  input wire logic [31:0] NET_IP,
  input wire logic [31:0] NET_MASK,
  input wire logic [31:0] NET_GW,
  input wire logic CFG_DONE
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!NRST);
  sequence s_cmd;
    WR && ADDR == `OFF_COMMAND && WDATA == `CMD_SOFT_RESET;
  endsequence
  // Pins only count at a capture, so check right where CFG_DONE rises
  sequence s_cap;
    $rose(CFG_DONE);
  endsequence
  chk_boot_done: assert property ($rose(NRST) |-> ##[1:20] CFG_DONE)
    else $error("no capture after reset");
  chk_soft_recap: assert property (s_cmd |-> ##[1:4] !CFG_DONE ##[1:20] CFG_DONE)
    else $error("soft reset did not recapture");
  chk_run_hold: assert property (
    CFG_DONE && $past(CFG_DONE) |-> $stable(SER_NODE) && $stable(SER_BAUD) && $stable(NET_IP))
    else $error("settings moved while running");
  chk_rate_field: assert property (
    s_cap ##0 (!NET_EN && DIP_SW[8:7] != 2'h0) |-> SER_BAUD == DIP_SW[8:7])
    else $error("rate field not applied");
  chk_net_octet: assert property (
    s_cap ##0 (NET_EN && !DIP_SW[8]) |->
      NET_IP == {`NET_PREFIX, (DIP_SW[7:0] > `NET_OCTET_MAX) ? `NET_DEFAULT_OCTET : DIP_SW[7:0]})
    else $error("network address wrong");
  chk_fb_shared: assert property (FB_EN |-> FB_NODE == SER_NODE && !NET_EN)
    else $error("fieldbus node differs");
  chk_node_range: assert property (
    CFG_DONE && SER_EN |-> SER_NODE >= `SER_ADDR_MIN && SER_NODE <= `SER_ADDR_MAX)
    else $error("serial node out of range");
  chk_baud_legal: assert property (CFG_DONE |-> SER_BAUD != 2'h0)
    else $error("serial rate unset");
endmodule
bind comm_dip_switch_config dip_cfg_asserts i_dip_cfg_asserts (
  .CLK(CLK), .NRST(NRST), .DIP_SW(DIP_SW), .FIELDBUS_CARD(FIELDBUS_CARD),
  .ETHERNET_CARD(ETHERNET_CARD), .SERIAL_FITTED(SERIAL_FITTED), .ADDR(ADDR),
  .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .SER_EN(SER_EN), .SER_NODE(SER_NODE),
  .SER_BAUD(SER_BAUD), .SER_STOP2(SER_STOP2), .SER_ODD(SER_ODD), .SER_ASCII(SER_ASCII),
  .FB_EN(FB_EN), .FB_NODE(FB_NODE), .NET_EN(NET_EN), .NET_IP(NET_IP),
  .NET_MASK(NET_MASK), .NET_GW(NET_GW), .CFG_DONE(CFG_DONE)
);

// File: tb/serial_peer_model.sv
// Second node on the shared serial line, as seen by the decoder
`timescale 1ns/1ps
module serial_peer_model #(
  parameter logic [7:0] PEER_NODE = 8'h02,
  parameter logic [1:0] PEER_BAUD = 2'h3
) (
  // Decoder settings
  input wire logic [7:0] node,
  input wire logic [1:0] baud,
  input wire logic done,
  // Line health
  output logic clash,
  output logic same
);
  // Peer keeps its own address and the line rate; a clash means two nodes answer
  assign clash = done && (node == PEER_NODE);
  assign same = done && (baud == PEER_BAUD);
endmodule
